// *** tad_class.v ***
// Purpose: classify a first opcode byte
// Assumes: clocked use inside the decoder, loaded by take_first
// Notes: registered output for timing
`timescale 1ns/10ps
`include "tad_consts.vh"
module tad_class (
   input wire clock,
   input wire rst_b,
   input wire load,
   input wire [7:0] op,
   output reg [3:0] kind,
   output reg two_byte
);
   reg [3:0] next_kind;
   reg next_two;
   // table of supported first bytes
   always @* begin
      next_two = 1'b1;
      case (op)
         `TAD_OP_SEG_LOAD: next_kind = `TAD_K_SEG_LOAD;
         `TAD_OP_SEG_STORE: next_kind = `TAD_K_SEG_STORE;
         `TAD_OP_LEA: next_kind = `TAD_K_LEA;
         `TAD_OP_LDS: next_kind = `TAD_K_LDS;
         `TAD_OP_LES: next_kind = `TAD_K_LES;
         `TAD_OP_LOOKUP: begin
            next_kind = `TAD_K_LOOKUP;
            next_two = 1'b0;
         end
         `TAD_OP_LOAD_FLAGS_INTO_HIGH_ACCUM: begin
            next_kind = `TAD_K_LOAD_FLAGS_INTO_HIGH_ACCUM;
            next_two = 1'b0;
         end
         `TAD_OP_STORE_HIGH_ACCUM_TO_FLAGS: begin
            next_kind = `TAD_K_STORE_HIGH_ACCUM_TO_FLAGS;
            next_two = 1'b0;
         end
         default: begin
            if ((op & `TAD_ADD_MASK) == `TAD_ADD_CODE) begin
               next_kind = `TAD_K_ADD;
            end else begin
               next_kind = `TAD_K_NONE;
               next_two = 1'b0;
            end
         end
      endcase
   end
   // capture on each first byte
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         kind <= `TAD_K_NONE;
         two_byte <= 1'b0;
      end else if (load) begin
         kind <= next_kind;
         two_byte <= next_two;
      end
   end
endmodule

// *** tad_consts.vh ***
// Purpose: constants for the transfer and add opcode decoder
// Assumes: opcode bytes arrive one per strobe from the prefetch queue
`ifndef TAD_CONSTS_VH
`define TAD_CONSTS_VH
`define TAD_OP_SEG_LOAD 8'h8e
`define TAD_OP_SEG_STORE 8'h8c
`define TAD_OP_LOOKUP 8'hd7
`define TAD_OP_LEA 8'h8d
`define TAD_OP_LDS 8'hc5
`define TAD_OP_LES 8'hc4
`define TAD_OP_LOAD_FLAGS_INTO_HIGH_ACCUM 8'h9f
`define TAD_OP_STORE_HIGH_ACCUM_TO_FLAGS 8'h9e
`define TAD_ADD_MASK 8'hfc
`define TAD_ADD_CODE 8'h00
`define TAD_W_BIT 0
`define TAD_D_BIT 1
`define TAD_MOD_HI 7
`define TAD_MOD_LO 6
`define TAD_REG_HI 5
`define TAD_REG_LO 3
`define TAD_RM_HI 2
`define TAD_RM_LO 0
`define TAD_SEG_RSV 5
`define TAD_MOD_REG 2'h3
// operation codes on op_kind
`define TAD_K_NONE 4'h0
`define TAD_K_SEG_LOAD 4'h1
`define TAD_K_SEG_STORE 4'h2
`define TAD_K_LOOKUP 4'h3
`define TAD_K_LEA 4'h4
`define TAD_K_LDS 4'h5
`define TAD_K_LES 4'h6
`define TAD_K_LOAD_FLAGS_INTO_HIGH_ACCUM 4'h7
`define TAD_K_STORE_HIGH_ACCUM_TO_FLAGS 4'h8
`define TAD_K_ADD 4'h9
`endif

// *** tad_decoder.v ***
// Purpose: decode transfer and add opcodes from the prefetch stream
// Assumes: byte_valid marks one instruction byte per cycle, in order
// Notes: results stand until the next decode completes
`timescale 1ns/10ps
`include "tad_consts.vh"
module tad_decoder (
   input wire clock,
   input wire rst_b,
   input wire byte_valid,
   input wire [7:0] byte_in,
   output reg decode_done,
   output reg [3:0] op_kind,
   output reg illegal,
   output reg word_op,
   output reg reg_is_dest,
   output reg [1:0] mode_field,
   output reg [2:0] reg_field,
   output reg [2:0] rm_field,
   output reg memory_access
);
   // one-hot sequencer states
   localparam S_FIRST = 3'b001; // waiting for a first byte
   localparam S_CLASS = 3'b010; // first byte being classified
   localparam S_MODRM = 3'b100; // waiting for the addressing byte
   reg [2:0] state;
   reg [2:0] next_state;
   reg [7:0] first;
   reg pend;
   reg [7:0] pend_byte;
   wire [3:0] kind;
   wire two_byte;
   wire take_first;
   wire finish_single;
   wire finish_pair;
   wire [7:0] modrm_now;

   // mode field of an addressing byte
   function [1:0] mode_of;
      input [7:0] b;
      begin
         mode_of = b[`TAD_MOD_HI:`TAD_MOD_LO];
      end
   endfunction

   // register field of an addressing byte
   function [2:0] reg_of;
      input [7:0] b;
      begin
         reg_of = b[`TAD_REG_HI:`TAD_REG_LO];
      end
   endfunction

   // register or memory field of an addressing byte
   function [2:0] rm_of;
      input [7:0] b;
      begin
         rm_of = b[`TAD_RM_HI:`TAD_RM_LO];
      end
   endfunction

   // the two segment move forms share the reserved-bit check
   function seg_form;
      input [3:0] k;
      begin
         seg_form = (k == `TAD_K_SEG_LOAD) || (k == `TAD_K_SEG_STORE);
      end
   endfunction

   // data access unless register-direct or an address-only load
   function touches_memory;
      input [3:0] k;
      input [7:0] b;
      begin
         touches_memory = (k != `TAD_K_LEA) && (mode_of(b) != `TAD_MOD_REG);
      end
   endfunction

   // only the add form carries a size bit; the rest are word wide
   function word_of;
      input [3:0] k;
      input [7:0] f;
      begin
         word_of = (k == `TAD_K_ADD) ? f[`TAD_W_BIT] : 1'b1;
      end
   endfunction

   // add follows its direction bit; segment store is the only source form
   function dest_of;
      input [3:0] k;
      input [7:0] f;
      begin
         dest_of = (k == `TAD_K_ADD) ? f[`TAD_D_BIT] : (k != `TAD_K_SEG_STORE);
      end
   endfunction

   // first-byte classifier, registered to keep the byte path short
   tad_class u_class (
      .clock(clock),
      .rst_b(rst_b),
      .load(take_first),
      .op(byte_in),
      .kind(kind),
      .two_byte(two_byte)
   );

   // step qualifiers
   assign take_first = (state == S_FIRST) && byte_valid;
   assign finish_single = (state == S_CLASS) && !two_byte;
   assign finish_pair = (state == S_MODRM) && (pend || byte_valid);
   // a byte caught during classify wins over the live bus
   assign modrm_now = pend ? pend_byte : byte_in;

   // sequence: first byte, classify, optional addressing byte
   always @* begin
      next_state = state;
      case (state)
         S_FIRST: begin
            if (byte_valid) begin
               next_state = S_CLASS;
            end
         end
         S_CLASS: begin
            if (two_byte) begin
               next_state = S_MODRM;
            end else begin
               next_state = S_FIRST;
            end
         end
         S_MODRM: begin
            if (pend || byte_valid) begin
               next_state = S_FIRST;
            end
         end
         default: next_state = S_FIRST;
      endcase
   end

   // state register
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_FIRST;
      end else begin
         state <= next_state;
      end
   end

   // first byte kept for the size and direction bits
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         first <= 8'h00;
      end else if (take_first) begin
         first <= byte_in;
      end
   end

   // a byte arriving while a two-byte form is classified is held for the addressing step
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pend <= 1'b0;
         pend_byte <= 8'h00;
      end else if ((state == S_CLASS) && two_byte && byte_valid) begin
         pend <= 1'b1;
         pend_byte <= byte_in;
      end else if (finish_pair) begin
         pend <= 1'b0;
      end
   end

   // one-cycle completion strobe
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         decode_done <= 1'b0;
      end else begin
         decode_done <= finish_single || finish_pair;
      end
   end

   // operation kind stands until the next completion
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         op_kind <= `TAD_K_NONE;
      end else if (finish_single || finish_pair) begin
         op_kind <= kind;
      end
   end

   // unknown first byte, or segment form with the reserved bit set
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         illegal <= 1'b0;
      end else if (finish_single) begin
         illegal <= (kind == `TAD_K_NONE);
      end else if (finish_pair) begin
         illegal <= seg_form(kind) && modrm_now[`TAD_SEG_RSV];
      end
   end

   // operand size; single-byte forms are byte wide
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         word_op <= 1'b0;
      end else if (finish_single) begin
         word_op <= 1'b0;
      end else if (finish_pair) begin
         word_op <= word_of(kind, first);
      end
   end

   // direction of the register field
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_is_dest <= 1'b0;
      end else if (finish_single) begin
         reg_is_dest <= 1'b0;
      end else if (finish_pair) begin
         reg_is_dest <= dest_of(kind, first);
      end
   end

   // addressing fields, zero for single-byte forms
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mode_field <= 2'h0;
         reg_field <= 3'h0;
         rm_field <= 3'h0;
      end else if (finish_single) begin
         mode_field <= 2'h0;
         reg_field <= 3'h0;
         rm_field <= 3'h0;
      end else if (finish_pair) begin
         mode_field <= mode_of(modrm_now);
         reg_field <= reg_of(modrm_now);
         rm_field <= rm_of(modrm_now);
      end
   end

   // lea computes the address only, never touches memory
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         memory_access <= 1'b0;
      end else if (finish_single) begin
         memory_access <= (kind == `TAD_K_LOOKUP);
      end else if (finish_pair) begin
         memory_access <= touches_memory(kind, modrm_now);
      end
   end
endmodule

// *** tad_decoder_sva.sv ***
// Purpose: decoder port checks
// Assumes: one clock domain
// Notes: bound to the decoder
`timescale 1ns/10ps
module tad_decoder_sva (
   input wire clock,
   input wire rst_b,
   input wire byte_valid,
   input wire [7:0] byte_in,
   input wire decode_done,
   input wire [3:0] op_kind,
   input wire illegal,
   input wire word_op,
   input wire reg_is_dest,
   input wire [1:0] mode_field,
   input wire [2:0] reg_field,
   input wire [2:0] rm_field,
   input wire memory_access
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // kind seen only while a result is presented
   wire [3:0] k = decode_done ? op_kind : 4'hf;
   chk_done_pulse: assert property (decode_done |=> !decode_done) else $error("done held");
   chk_result_hold: assert property (!decode_done |-> $stable(op_kind) && $stable(word_op)) else $error("moved");
   chk_seg_load: assert property (k == 4'h1 |-> reg_is_dest && word_op) else $error("seg load");
   chk_seg_store: assert property (k == 4'h2 |-> !reg_is_dest && word_op) else $error("seg store");
   chk_lookup_mem:
      assert property (k == 4'h3 |-> memory_access && $past(byte_in, 2) == 8'hd7) else $error("lookup");
   chk_ea_nomem: assert property (k == 4'h4 |-> !memory_access && reg_is_dest) else $error("ea");
   chk_far_ptr:
      assert property (k == 4'h5 || k == 4'h6 |-> word_op && memory_access == (mode_field != 2'h3)) else $error("far");
   chk_flag_move:
      assert property (k == 4'h7 || k == 4'h8 |-> !word_op && $past(byte_in, 2) == {7'h4f, k == 4'h7}) else $error("flag");
   chk_add_form: assert property (k == 4'h9 |-> memory_access == (mode_field != 2'h3)) else $error("add");
   cover property (k == 4'h9 && word_op);
   cover property (k == 4'h3);
   cover property (decode_done && illegal);
endmodule
bind tad_decoder tad_decoder_sva chk (.*);

// *** tad_queue_model.sv ***
// Purpose: prefetch queue stand-in
// Assumes: send is entered 1 ns after a rising edge
// Notes: slow mode stalls one cycle before the addressing byte
`timescale 1ns/10ps
module tad_queue_model (
   input wire clock,
   output reg byte_valid,
   output reg [7:0] byte_in
);
   initial begin
      byte_valid = 1'b0;
      byte_in = 8'h00;
   end
   // idle lines carry the inverse of the last byte, never a stale copy
   task send(input [7:0] b0, input [7:0] b1, input two, input slow);
      begin
         byte_valid = 1'b1;
         byte_in = b0;
         @(posedge clock);
         #1;
         if (two && slow) begin
            byte_valid = 1'b0;
            byte_in = ~b0;
            @(posedge clock);
            #1;
         end
         byte_valid = two;
         byte_in = two ? b1 : ~b0;
         if (two) begin
            @(posedge clock);
            #1;
            byte_valid = 1'b0;
            byte_in = ~b1;
         end
      end
   endtask
endmodule

// *** test_transfer_and_add_opcode_decode.sv ***
// Purpose: self-checking bench for the opcode decoder
// Assumes: queue model feeds bytes, fast then slow
// Notes: unknown bytes check kind and flag only
`timescale 1ns/10ps
module test_transfer_and_add_opcode_decode;
   reg clock = 1'b0;
   reg rst_b = 1'b0;
   wire byte_valid, decode_done, illegal, word_op, reg_is_dest, memory_access;
   wire [7:0] byte_in;
   wire [3:0] op_kind;
   wire [1:0] mode_field;
   wire [2:0] reg_field, rm_field;
   integer num_errors = 0, comparisons = 0, j, n, lat;
   reg [7:0] b0, b1;
   reg [15:0] exp, mask;
   // low eight entries are the fixed opcodes in kind order
   reg [103:0] tbl = {8'hff, 8'h03, 8'h02, 8'h01, 8'h00, 8'h9e, 8'h9f, 8'hc4, 8'hc5, 8'h8d, 8'hd7, 8'h8c, 8'h8e};
   always #4 clock = ~clock;
   tad_queue_model q (.*);
   tad_decoder dut (.*);
   task check(input [63:0] nm, input [15:0] e, input [15:0] s, input [15:0] m);
      begin
         comparisons = comparisons + 1;
         if ((s & m) !== (e & m)) begin
            num_errors = num_errors + 1;
            $display("BAD %0s exp %h got %h", nm, e & m, s & m);
         end
      end
   endtask
   // reference result with mask; single bytes leave the direction bit open
   function [31:0] model(input [7:0] a, input [7:0] b);
      integer t;
      reg [3:0] k;
      begin
         k = a[7:2] == 6'h00 ? 4'h9 : 4'h0;
         for (t = 1; t < 9; t = t + 1)
            if (a == tbl[8 * t - 8 +: 8]) k = t[3:0];
         if (k == 4'h0) model = {16'hf800, 16'h0800};
         else if (k == 4'h3 || k == 4'h7 || k == 4'h8) model = {16'hfdff, k, 11'h000, k == 4'h3};
         else model = {16'hffff, k, (k == 4'h1 || k == 4'h2) && b[5], k != 4'h9 || a[0], k == 4'h9 ? a[1] : k != 4'h2, b,
                       b[7:6] != 2'h3 && k != 4'h4};
      end
   endfunction
   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, num_errors);
         if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // about 75 cycles expected; 5000 allowed
   initial begin
      #40000;
      num_errors = num_errors + 1;
      end_sim;
   end
   initial begin
      n = $urandom(92959);
      repeat (4) @(posedge clock);
      #1 rst_b = 1'b1;
      for (j = 0; j < 26; j = j + 1) begin
         b0 = tbl[8 * (j % 13) +: 8];
         b1 = $urandom;
         b1[5] = j > 12 ? (b1[5] || b0[7:2] == 6'h23) : (b1[5] && b0[7:2] != 6'h23);
         {mask, exp} = model(b0, b1);
         q.send(b0, b1, mask == 16'hffff, j > 12);
         lat = 0;
         while (decode_done !== 1'b1 && lat < 4) begin
            @(posedge clock);
            #1;
            lat = lat + 1;
         end
         check("latency", (mask == 16'hffff && j > 12) ? 16'h0000 : 16'h0001, lat[15:0], 16'hffff);
         check("decode", exp, {op_kind, illegal, word_op, reg_is_dest, mode_field, reg_field, rm_field,
                memory_access}, mask);
         $display("test %0d op %h done", j, b0);
      end
      end_sim;
   end
endmodule
